//--- verilog/fbabc_device.sv
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module fbabc_device (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  fbabc_link_if.device link,
  input wire logic [7:0] mem_rdata_i,
  output logic [31:0] rd_addr_o,
  output logic rd_stb_o,
  output logic [7:0] bank_o,
  output logic [7:0] cfg1_o,
  output logic wel_o
);
  typedef enum logic [2:0] {D_CMD, D_ADDR, D_DUMMY, D_OUT, D_WBANK, D_WCFG, D_IGNORE} fbabc_dst_t;

  typedef struct packed {
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic sclk_q;
    logic cs_q;
    fbabc_dst_t st;
    logic [2:0] bitcnt;
    logic [2:0] acnt;
    logic [6:0] sh;
    logic [7:0] opc;
    logic [31:0] addr;
    logic [7:0] outsh;
    logic load_pend;
    logic [7:0] bank;
    logic [7:0] bank_pend;
    logic bank_wr;
    logic [7:0] cfg1;
    logic [7:0] cfg_pend;
    logic cfg_wr;
    logic wel;
    logic wel_set;
    logic srst;
    logic miso;
    logic miso_oe;
    logic [31:0] rd_addr;
    logic rd_stb;
  } fbabc_dev_t;

  fbabc_dev_t s_r;
  fbabc_dev_t s_nxt;
  logic [7:0] byte_v;
  logic [7:0] src;
  logic rise;
  logic fall;
  logic sel;

  // address seen by the array: full word, or segment bits from the bank
  function automatic logic [31:0] fbabc_eff(input logic [31:0] a, input logic [7:0] op, input logic [7:0] bk);
    logic [31:0] r;
    r = a;
    if (op != fbabc_pkg::OP_READ4 && !bk[fbabc_pkg::BANK_4B_BIT]) begin // R04
      r = {1'b0, bk[6:0], a[23:0]}; // R02
    end
    return r;
  endfunction

  always_comb begin
    s_nxt = s_r;
    byte_v = {s_r.sh, s_r.sy2[fbabc_pkg::SY_DQ0]};
    src = mem_rdata_i;
    case (s_r.opc)
      fbabc_pkg::OP_RD_BANK: begin
        src = s_r.bank; // R03
      end
      fbabc_pkg::OP_SFDP: begin
        if (s_r.addr[23:2] == fbabc_pkg::SFDP_DW16_WORD) begin
          src = fbabc_pkg::SFDP_DW16[{s_r.addr[1:0], 3'h0} +: 8]; // R09
        end else begin
          src = fbabc_pkg::SFDP_BLANK;
        end
      end
      default: begin
        src = mem_rdata_i;
      end
    endcase
    s_nxt.sy1 = {link.quad_data_lines[0], link.cs_n, link.sclk};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sclk_q = s_r.sy2[fbabc_pkg::SY_SCLK];
    s_nxt.cs_q = s_r.sy2[fbabc_pkg::SY_CS_N];
    s_nxt.rd_stb = 1'b0;
    rise = s_r.sy2[fbabc_pkg::SY_SCLK] & ~s_r.sclk_q;
    fall = ~s_r.sy2[fbabc_pkg::SY_SCLK] & s_r.sclk_q;
    sel = ~s_r.sy2[fbabc_pkg::SY_CS_N];
    if (!sel) begin
      s_nxt.st = D_CMD;
      s_nxt.bitcnt = 3'h0;
      s_nxt.miso_oe = 1'b0;
      s_nxt.load_pend = 1'b0;
      if (!s_r.cs_q) begin
        // commands take effect only once select rises
        if (s_r.srst) begin
          s_nxt.bank = fbabc_pkg::BANK_RESET; // R06
          s_nxt.wel = 1'b0; // R05
        end else begin
          if (s_r.bank_wr) begin
            s_nxt.bank = s_r.bank_pend; // R11
          end
          if (s_r.cfg_wr) begin
            s_nxt.cfg1 = s_r.cfg_pend; // R08
            s_nxt.wel = 1'b0;
          end else if (s_r.wel_set) begin
            s_nxt.wel = 1'b1; // R08
          end
        end
        s_nxt.srst = 1'b0;
        s_nxt.bank_wr = 1'b0;
        s_nxt.cfg_wr = 1'b0;
        s_nxt.wel_set = 1'b0;
      end
    end else if (rise) begin
      s_nxt.sh = byte_v[6:0];
      s_nxt.bitcnt = s_r.bitcnt + 3'h1;
      if (s_r.bitcnt == 3'h7) begin
        case (s_r.st)
          D_CMD: begin
            s_nxt.opc = byte_v;
            s_nxt.addr = 32'h0;
            s_nxt.st = D_IGNORE;
            case (byte_v)
              fbabc_pkg::OP_RD_BANK: begin
                s_nxt.st = D_OUT; // R03
                s_nxt.load_pend = 1'b1;
              end
              fbabc_pkg::OP_WR_BANK: begin
                s_nxt.st = D_WBANK; // R03
              end
              fbabc_pkg::OP_SOFT_RST: begin
                s_nxt.srst = 1'b1; // R06
              end
              fbabc_pkg::OP_WR_EN: begin
                s_nxt.wel_set = 1'b1; // R08
              end
              fbabc_pkg::OP_WR_CFG1: begin
                if (s_r.wel) begin
                  s_nxt.st = D_WCFG; // R08
                end
              end
              fbabc_pkg::OP_READ: begin
                s_nxt.st = D_ADDR;
                if (s_r.bank[fbabc_pkg::BANK_4B_BIT]) begin
                  s_nxt.acnt = fbabc_pkg::ADDR_BYTES_4; // R01
                end else begin
                  s_nxt.acnt = fbabc_pkg::ADDR_BYTES_3; // R02
                end
              end
              fbabc_pkg::OP_READ4: begin
                s_nxt.st = D_ADDR;
                s_nxt.acnt = fbabc_pkg::ADDR_BYTES_4; // R04
              end
              fbabc_pkg::OP_SFDP: begin
                s_nxt.st = D_ADDR;
                s_nxt.acnt = fbabc_pkg::ADDR_BYTES_3;
              end
              default: begin
                s_nxt.st = D_IGNORE;
              end
            endcase
          end
          D_ADDR: begin
            s_nxt.addr = {s_r.addr[23:0], byte_v};
            s_nxt.acnt = s_r.acnt - 3'h1;
            if (s_r.acnt == 3'h1) begin
              if (s_r.opc == fbabc_pkg::OP_SFDP) begin
                s_nxt.st = D_DUMMY;
              end else begin
                s_nxt.st = D_OUT;
                s_nxt.load_pend = 1'b1;
                s_nxt.rd_stb = 1'b1;
                s_nxt.rd_addr = fbabc_eff({s_r.addr[23:0], byte_v}, s_r.opc, s_r.bank); // R01
              end
            end
          end
          D_DUMMY: begin
            s_nxt.st = D_OUT;
            s_nxt.load_pend = 1'b1;
          end
          D_OUT: begin
            s_nxt.load_pend = 1'b1;
            if (s_r.opc != fbabc_pkg::OP_RD_BANK) begin
              s_nxt.addr = s_r.addr + 32'h1;
            end
            if (s_r.opc == fbabc_pkg::OP_READ || s_r.opc == fbabc_pkg::OP_READ4) begin
              s_nxt.rd_stb = 1'b1;
              s_nxt.rd_addr = fbabc_eff(s_r.addr + 32'h1, s_r.opc, s_r.bank);
            end
          end
          D_WBANK: begin
            s_nxt.bank_pend = byte_v; // R03
            s_nxt.bank_wr = 1'b1;
            s_nxt.st = D_IGNORE;
          end
          D_WCFG: begin
            s_nxt.cfg_pend = byte_v;
            s_nxt.cfg_wr = 1'b1;
            s_nxt.st = D_IGNORE;
          end
          default: begin
            s_nxt.st = D_IGNORE;
          end
        endcase
      end
    end else if (fall && s_r.st == D_OUT) begin
      s_nxt.miso_oe = 1'b1;
      if (s_r.load_pend) begin
        s_nxt.miso = src[7];
        s_nxt.outsh = {src[6:0], 1'b0};
        s_nxt.load_pend = 1'b0;
      end else begin
        s_nxt.miso = s_r.outsh[7];
        s_nxt.outsh = {s_r.outsh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.bank <= fbabc_pkg::BANK_RESET; // R12
      s_r.cfg1 <= fbabc_pkg::CFG1_RESET; // R05
      s_r.sy1 <= 3'h2;
      s_r.sy2 <= 3'h2;
      s_r.cs_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.dev_dq_o = {2'b00, s_r.miso, 1'b0};
  assign link.dev_dq_oe = {2'b00, s_r.miso_oe, 1'b0};
  assign rd_addr_o = s_r.rd_addr;
  assign rd_stb_o = s_r.rd_stb;
  assign bank_o = s_r.bank;
  assign cfg1_o = s_r.cfg1;
  assign wel_o = s_r.wel;
endmodule // fbabc_device

//--- verilog/fbabc_pkg.sv
// Function
// R01 - bank bit 7 selects four address bytes
// R02 - bit 7 low: bank bits give segment
// R03 - 16h reads bank, 17h writes one byte
// R04 - dedicated read always takes four address bytes
// R05 - any reset returns to three byte mode
// R06 - F0h soft reset clears four byte mode
// R07 - host exits quad mode before reset
// R08 - 06h must precede config register write
// R09 - parameter bytes 3Ch-3Fh read A8FA28F0h
// R10 - quad exit: ones on four lines, eight clocks
// R11 - bank write acts from next command
// R12 - bank reads zero after any reset
package fbabc_pkg;
  localparam logic [7:0] OP_RD_BANK = 8'h16;
  localparam logic [7:0] OP_WR_BANK = 8'h17;
  localparam logic [7:0] OP_SOFT_RST = 8'hf0;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_CFG1 = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ4 = 8'h13;
  localparam logic [7:0] OP_SFDP = 8'h5a;
  localparam int BANK_4B_BIT = 7;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [31:0] SFDP_DW16 = 32'ha8fa28f0;
  localparam logic [21:0] SFDP_DW16_WORD = 22'h00000f;
  localparam logic [7:0] SFDP_BLANK = 8'hff;
  localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
  localparam int SY_SCLK = 0;
  localparam int SY_CS_N = 1;
  localparam int SY_DQ0 = 2;
  localparam int CORE_CLK_MHZ = 20;
  localparam int SCLK_HALF_NS = 200;
  localparam logic [2:0] SCLK_HALF_CYC = 3'((SCLK_HALF_NS * CORE_CLK_MHZ + 999) / 1000);
  localparam logic [5:0] EXIT_CLOCKS = 6'h08;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int CMD_ADDR4_BIT = 3;
  localparam int STATUS_RX_LSB = 8;
  localparam logic [2:0] HOP_RD_BANK = 3'h0;
  localparam logic [2:0] HOP_WR_BANK = 3'h1;
  localparam logic [2:0] HOP_SOFT_RST = 3'h2;
  localparam logic [2:0] HOP_WR_EN = 3'h3;
  localparam logic [2:0] HOP_WR_CFG1 = 3'h4;
  localparam logic [2:0] HOP_SFDP = 3'h5;
  localparam logic [2:0] HOP_READ = 3'h6;
  localparam logic [2:0] HOP_READ4 = 3'h7;
endpackage

//--- verilog/fbabc_link_if.sv
`timescale 1ns/1ns
interface fbabc_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_dq_o;
  logic [3:0] host_dq_oe;
  logic [3:0] dev_dq_o;
  logic [3:0] dev_dq_oe;
  logic [3:0] quad_data_lines;
  // undriven lines float high through a pull-up
  for (genvar i = 0; i < 4; i++) begin : g_line
    assign quad_data_lines[i] = host_dq_oe[i] ? host_dq_o[i] : (dev_dq_oe[i] ? dev_dq_o[i] : 1'b1);
  end
  modport host (output sclk, output cs_n, output host_dq_o, output host_dq_oe, input quad_data_lines);
  modport device (input sclk, input cs_n, input quad_data_lines, output dev_dq_o, output dev_dq_oe);
endinterface

//--- verilog/fbabc_host.sv
`timescale 1ns/1ns
module fbabc_host (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  fbabc_link_if.host link,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic busy_o
);
  typedef enum logic [2:0] {H_IDLE, H_LOAD, H_XFER, H_END, H_GAP} fbabc_hst_t;

  typedef struct packed {
    logic dq1_s1;
    logic dq1_s2;
    fbabc_hst_t st;
    logic [2:0] div;
    logic sclk;
    logic cs_n;
    logic [3:0] dq_o;
    logic [3:0] dq_oe;
    logic quad;
    logic [47:0] txbuf;
    logic [5:0] ntx;
    logic [5:0] nrx;
    logic [5:0] bitidx;
    logic [7:0] rx;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [31:0] rdata;
    logic busy;
  } fbabc_host_t;

  fbabc_host_t s_r;
  fbabc_host_t s_nxt;
  logic [2:0] op;
  logic half_done;

  always_comb begin
    s_nxt = s_r;
    op = reg_wdata_i[2:0];
    half_done = (s_r.div == fbabc_pkg::SCLK_HALF_CYC - 3'h1);
    s_nxt.dq1_s1 = link.quad_data_lines[1];
    s_nxt.dq1_s2 = s_r.dq1_s1;
    s_nxt.rdata = 32'h0;
    s_nxt.div = half_done ? 3'h0 : s_r.div + 3'h1;
    if (reg_rd_i) begin
      case (reg_addr_i)
        fbabc_pkg::REG_ADDR: s_nxt.rdata = s_r.addr;
        fbabc_pkg::REG_WDATA: s_nxt.rdata = {24'h0, s_r.wdata};
        fbabc_pkg::REG_STATUS: s_nxt.rdata = {16'h0, s_r.rx, 7'h0, s_r.busy};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    if (reg_wr_i && reg_addr_i == fbabc_pkg::REG_ADDR) begin
      s_nxt.addr = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == fbabc_pkg::REG_WDATA) begin
      s_nxt.wdata = reg_wdata_i[7:0];
    end
    case (s_r.st)
      H_IDLE: begin
        if (reg_wr_i && reg_addr_i == fbabc_pkg::REG_CMD) begin
          s_nxt.st = H_LOAD;
          s_nxt.busy = 1'b1;
          s_nxt.bitidx = 6'h0;
          s_nxt.rx = 8'h0;
          s_nxt.quad = 1'b0;
          s_nxt.ntx = 6'd8;
          s_nxt.nrx = 6'd0;
          s_nxt.txbuf = 48'h0;
          case (op)
            fbabc_pkg::HOP_RD_BANK: begin
              s_nxt.txbuf = {fbabc_pkg::OP_RD_BANK, 40'h0}; // R03
              s_nxt.nrx = 6'd8;
            end
            fbabc_pkg::HOP_WR_BANK: begin
              s_nxt.txbuf = {fbabc_pkg::OP_WR_BANK, s_r.wdata, 32'h0}; // R03
              s_nxt.ntx = 6'd16;
            end
            fbabc_pkg::HOP_SOFT_RST: begin
              s_nxt.txbuf = {fbabc_pkg::OP_SOFT_RST, 40'h0}; // R06
              s_nxt.quad = 1'b1; // R07
              s_nxt.ntx = fbabc_pkg::EXIT_CLOCKS;
            end
            fbabc_pkg::HOP_WR_EN: begin
              s_nxt.txbuf = {fbabc_pkg::OP_WR_EN, 40'h0}; // R08
            end
            fbabc_pkg::HOP_WR_CFG1: begin
              s_nxt.txbuf = {fbabc_pkg::OP_WR_CFG1, s_r.wdata, 32'h0};
              s_nxt.ntx = 6'd16;
            end
            fbabc_pkg::HOP_SFDP: begin
              s_nxt.txbuf = {fbabc_pkg::OP_SFDP, s_r.addr[23:0], 16'h0};
              s_nxt.ntx = 6'd40;
              s_nxt.nrx = 6'd8;
            end
            fbabc_pkg::HOP_READ: begin
              s_nxt.nrx = 6'd8;
              if (reg_wdata_i[fbabc_pkg::CMD_ADDR4_BIT]) begin
                s_nxt.txbuf = {fbabc_pkg::OP_READ, s_r.addr, 8'h0}; // R01
                s_nxt.ntx = 6'd40;
              end else begin
                s_nxt.txbuf = {fbabc_pkg::OP_READ, s_r.addr[23:0], 16'h0}; // R02
                s_nxt.ntx = 6'd32;
              end
            end
            default: begin
              s_nxt.txbuf = {fbabc_pkg::OP_READ4, s_r.addr, 8'h0}; // R04
              s_nxt.ntx = 6'd40;
              s_nxt.nrx = 6'd8;
            end
          endcase
        end
      end
      H_LOAD: begin
        s_nxt.cs_n = 1'b0;
        s_nxt.sclk = 1'b0;
        s_nxt.div = 3'h0;
        s_nxt.bitidx = 6'h0;
        s_nxt.st = H_XFER;
        if (s_r.quad) begin
          s_nxt.dq_o = 4'hf; // R10
          s_nxt.dq_oe = 4'hf;
        end else begin
          s_nxt.dq_o = {3'h0, s_r.txbuf[47]};
          s_nxt.dq_oe = 4'h1;
          s_nxt.txbuf = {s_r.txbuf[46:0], 1'b0};
        end
      end
      H_XFER: begin
        if (half_done) begin
          if (!s_r.sclk) begin
            s_nxt.sclk = 1'b1;
          end else begin
            s_nxt.sclk = 1'b0;
            s_nxt.bitidx = s_r.bitidx + 6'h1;
            if (s_r.bitidx >= s_r.ntx) begin
              s_nxt.rx = {s_r.rx[6:0], s_r.dq1_s2};
            end
            if (!s_r.quad) begin
              s_nxt.dq_o = {3'h0, s_r.txbuf[47]};
              s_nxt.txbuf = {s_r.txbuf[46:0], 1'b0};
            end
            if (s_r.bitidx == s_r.ntx + s_r.nrx - 6'h1) begin
              s_nxt.st = H_END; // R10
            end
          end
        end
      end
      H_END: begin
        if (half_done) begin
          s_nxt.cs_n = 1'b1;
          s_nxt.dq_oe = 4'h0;
          s_nxt.st = H_GAP;
        end
      end
      H_GAP: begin
        if (half_done) begin
          if (s_r.quad) begin
            s_nxt.quad = 1'b0; // R07
            s_nxt.ntx = 6'd8;
            s_nxt.st = H_LOAD;
          end else begin
            s_nxt.busy = 1'b0;
            s_nxt.st = H_IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.cs_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.sclk = s_r.sclk;
  assign link.cs_n = s_r.cs_n;
  assign link.host_dq_o = s_r.dq_o;
  assign link.host_dq_oe = s_r.dq_oe;
  assign reg_rdata_o = s_r.rdata;
  assign busy_o = s_r.busy;
endmodule // fbabc_host

//--- verification/fbabc_link_chk.sv
`timescale 1ns/1ns
module fbabc_link_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_dq_o,
  input wire logic [3:0] host_dq_oe,
  input wire logic [3:0] dev_dq_o,
  input wire logic [3:0] dev_dq_oe,
  input wire logic [3:0] quad_data_lines
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sclk_idle_a: assert property (cs_n |-> !sclk) else $error("serial clock moved while deselected");
  lead_in_a: assert property ($fell(cs_n) |-> !sclk [*3]) else $error("serial clock rose too soon after select");
  high_phase_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("serial clock high phase wrong");
  dq0_setup_a: assert property ((!cs_n && $changed(host_dq_o[0])) |-> !sclk) else $error("host data moved while clock high");
  dev_lane_a: assert property ((dev_dq_oe & 4'hd) == 4'h0) else $error("device drives a lane other than its output");
  one_driver_a: assert property (dev_dq_oe[1] |-> quad_data_lines[1] == dev_dq_o[1]) else $error("device output overdriven");
  host_release_a: assert property ($rose(cs_n) |-> host_dq_oe == 4'h0) else $error("host still drives after deselect");
  dev_release_a: assert property ($rose(cs_n) |-> ##[0:5] !dev_dq_oe[1]) else $error("device kept driving after deselect");
  frame_gap_a: assert property ($rose(cs_n) |-> cs_n [*5]) else $error("commands too close together");
  quad_exit_a: assert property (host_dq_oe == 4'hf |-> quad_data_lines == 4'hf && !cs_n) else $error("exit fill not all ones");

  cover property (host_dq_oe == 4'hf);
  cover property ($rose(dev_dq_oe[1]));
  cover property ($rose(cs_n));
endmodule // fbabc_link_chk

//--- verification/four_byte_address_bank_control_tb.sv
`timescale 1ns/1ns
module four_byte_address_bank_control_tb;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic [31:0] reg_rdata;
  logic [31:0] rd_addr;
  logic [31:0] first_addr = 32'h0;
  logic busy;
  logic rd_stb;
  logic got = 1'b0;
  logic [7:0] bank;
  logic [7:0] cfg1;
  logic [7:0] rx;
  logic [31:0] s;
  logic wel;
  int bad_count = 0;
  int cmp_count = 0;
  fbabc_link_if fbabc_link_if_i ();
  fbabc_host fbabc_host_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(fbabc_link_if_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .busy_o(busy));
  fbabc_device fbabc_device_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(fbabc_link_if_i),
    .mem_rdata_i(mem_rdata), .rd_addr_o(rd_addr), .rd_stb_o(rd_stb), .bank_o(bank), .cfg1_o(cfg1), .wel_o(wel));
  fbabc_link_chk fbabc_link_chk_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk(fbabc_link_if_i.sclk),
    .cs_n(fbabc_link_if_i.cs_n), .host_dq_o(fbabc_link_if_i.host_dq_o), .host_dq_oe(fbabc_link_if_i.host_dq_oe),
    .dev_dq_o(fbabc_link_if_i.dev_dq_o), .dev_dq_oe(fbabc_link_if_i.dev_dq_oe),
    .quad_data_lines(fbabc_link_if_i.quad_data_lines));

  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  // array data is a fixed function of the address so reads can be predicted
  // first strobe of each command is kept; the capture re-arms while the host is idle
  always @(posedge core_clk_i) begin
    mem_rdata <= rd_addr[7:0] ^ 8'h5a;
    if (!busy) begin
      got <= 1'b0;
    end else if (rd_stb && !got) begin
      first_addr <= rd_addr;
      got <= 1'b1;
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask
  task bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task wait_done(output logic [7:0] r);
    logic [31:0] st;
    int n;
    n = 0;
    repeat (2) @(posedge core_clk_i);
    #1;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    check("idle", busy, 32'h0);
    bus_read(fbabc_pkg::REG_STATUS, st);
    r = st[15:8];
  endtask
  task run_op(input logic [3:0] op, input logic [31:0] a, input logic [7:0] wd, output logic [7:0] r);
    bus_write(fbabc_pkg::REG_ADDR, a);
    bus_write(fbabc_pkg::REG_WDATA, {24'h0, wd});
    bus_write(fbabc_pkg::REG_CMD, {28'h0, op});
    wait_done(r);
  endtask

  task t_reset;
    check("bank", bank, 32'h0);
    check("cfg1", cfg1, 32'h0);
    check("wel", wel, 32'h0);
    bus_read(4'h2, s);
    check("unmapped", s, 32'h0);
    run_op({1'b0, fbabc_pkg::HOP_RD_BANK}, 32'h0, 8'h00, rx);
    check("bank_read", rx, 32'h0);
    $display("test reset done");
  endtask
  task t_bank3;
    bus_write(fbabc_pkg::REG_WDATA, 32'h05);
    bus_write(fbabc_pkg::REG_CMD, {29'h0, fbabc_pkg::HOP_WR_BANK});
    wait (fbabc_link_if_i.cs_n === 1'b0);
    @(posedge fbabc_link_if_i.cs_n);
    #1 check("bank_hold", bank, 32'h0);
    wait_done(rx);
    check("bank_wr", bank, 32'h05);
    run_op({1'b0, fbabc_pkg::HOP_READ}, 32'h00123456, 8'h00, rx);
    check("seg_addr", first_addr, 32'h05123456);
    check("seg_data", rx, 32'h0c);
    run_op({1'b0, fbabc_pkg::HOP_READ4}, 32'h7bcdef01, 8'h00, rx);
    check("rd4_addr", first_addr, 32'h7bcdef01);
    check("rd4_data", rx, 32'h5b);
    $display("test bank3 done");
  endtask
  task t_bank4;
    run_op({1'b0, fbabc_pkg::HOP_WR_BANK}, 32'h0, 8'h85, rx);
    run_op({1'b1, fbabc_pkg::HOP_READ}, 32'h0abcdef0, 8'h00, rx);
    check("addr4", first_addr, 32'h0abcdef0);
    run_op({1'b0, fbabc_pkg::HOP_RD_BANK}, 32'h0, 8'h00, rx);
    check("bank_rd85", rx, 32'h85);
    run_op({1'b0, fbabc_pkg::HOP_SOFT_RST}, 32'h0, 8'h00, rx);
    check("soft_rst", bank, 32'h0);
    run_op({1'b0, fbabc_pkg::HOP_READ}, 32'h00000010, 8'h00, rx);
    check("addr3_again", first_addr, 32'h00000010);
    run_op({1'b0, fbabc_pkg::HOP_WR_BANK}, 32'h0, 8'h85, rx);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1 check("hw_rst", bank, 32'h0);
    $display("test bank4 done");
  endtask
  task t_cfg;
    run_op({1'b0, fbabc_pkg::HOP_WR_CFG1}, 32'h0, 8'h3c, rx);
    check("cfg_locked", cfg1, 32'h0);
    run_op({1'b0, fbabc_pkg::HOP_WR_EN}, 32'h0, 8'h00, rx);
    check("wel_set", wel, 32'h1);
    run_op({1'b0, fbabc_pkg::HOP_WR_CFG1}, 32'h0, 8'h3c, rx);
    check("cfg_wr", cfg1, 32'h3c);
    check("wel_clr", wel, 32'h0);
    $display("test cfg done");
  endtask
  task t_sfdp;
    logic [7:0] e [5];
    e = '{8'hff, 8'hf0, 8'h28, 8'hfa, 8'ha8};
    for (int i = 0; i < 5; i++) begin
      run_op({1'b0, fbabc_pkg::HOP_SFDP}, 32'h3b + i, 8'h00, rx);
      check("sfdp", rx, {24'h0, e[i]});
    end
    $display("test sfdp done");
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_bank3;
    t_bank4;
    t_cfg;
    t_sfdp;
    finish_test;
  end
endmodule // four_byte_address_bank_control_tb
